// *** core/lcss_top.sv ***
// lcd common scan shifter: wishbone slave, crossings and row level drive
`timescale 1ns/1ns
module lcss_top #(
    parameter int NUM_ROWS = lcss_pkg::NUM_ROWS,
    parameter int HALF_ROWS = lcss_pkg::HALF_ROWS
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic scan_shift_clock_i,
    input wire logic low_end_data_io_i,
    output logic low_end_data_io_o,
    output logic low_end_data_io_oe_o,
    input wire logic high_end_data_io_i,
    output logic high_end_data_io_o,
    output logic high_end_data_io_oe_o,
    input wire logic second_chain_input_i,
    input wire logic chain_split_i,
    input wire logic shift_direction_select_i,
    input wire logic ac_phase_i,
    input wire logic display_blank_n_i,
    output logic [NUM_ROWS-1:0][1:0] row_level_o
);
    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        logic drive_en;
        logic [1:0] mode_sy;
        logic [1:0] dir_sy;
        logic [1:0] phase_sy;
        logic [1:0] blank_n_sy;
        logic [2:0] tgl_sy;
        logic [NUM_ROWS-1:0] scan;
        logic [lcss_pkg::SHIFT_CNT_W-1:0] shifts;
        logic low_oe;
        logic high_oe;
        lcss_pkg::lcss_level_t [NUM_ROWS-1:0] rows;
    } lcss_top_t;

    lcss_top_t st;
    lcss_top_t next_st;
    logic req;
    logic shift_seen;
    logic [lcss_pkg::SCAN_W-1:0] scan_ext;
    logic [31:0] status_w;
    logic [NUM_ROWS-1:0] row_is_sel;

    if (NUM_ROWS > lcss_pkg::SCAN_W || NUM_ROWS != 2 * HALF_ROWS) begin : g_bad_rows
        $error("lcss_top: row count not served by the scan readback");
    end

    lcss_link_if #(.NUM_ROWS(NUM_ROWS)) lnk ();

    lcss_shifter #(
        .NUM_ROWS(NUM_ROWS),
        .HALF_ROWS(HALF_ROWS)
    ) u_shifter (
        .scan_shift_clock_i(scan_shift_clock_i),
        .lnk(lnk.shifter)
    );

    // data pins and selects belong to the link clock; the shifter samples them
    // chain select steers
    assign lnk.dual_mode = chain_split_i;
    assign lnk.shift_down = shift_direction_select_i;
    assign lnk.low_in = low_end_data_io_i;
    assign lnk.high_in = high_end_data_io_i;
    assign lnk.second_in = second_chain_input_i;

    assign low_end_data_io_o = lnk.stage[0];
    assign high_end_data_io_o = lnk.stage[NUM_ROWS-1];

    function automatic lcss_pkg::lcss_level_t row_level(
        input logic sel,
        input logic phase,
        input logic show
    );
        lcss_pkg::lcss_level_t lvl;
        if (phase) begin
            lvl = (sel && show) ? lcss_pkg::LVL_BOTTOM_SEL : lcss_pkg::LVL_LOWER_NONSEL;
        end else begin
            lvl = (sel && show) ? lcss_pkg::LVL_TOP_SEL : lcss_pkg::LVL_UPPER_NONSEL;
        end
        return lvl;
    endfunction : row_level

    assign req = wb_cyc_i && wb_stb_i && !st.ack;
    // toggle edge seen only after two flops, scan bits settled by then
    assign shift_seen = st.tgl_sy[2] != st.tgl_sy[1];
    assign scan_ext = lcss_pkg::SCAN_W'(st.scan);

    always_comb begin
        status_w = '0;
        status_w[lcss_pkg::ST_MODE_BIT] = st.mode_sy[1];
        status_w[lcss_pkg::ST_DIR_BIT] = st.dir_sy[1];
        status_w[lcss_pkg::ST_PHASE_BIT] = st.phase_sy[1];
        status_w[lcss_pkg::ST_BLANK_N_BIT] = st.blank_n_sy[1];
        status_w[lcss_pkg::ST_COUNT_LSB +: lcss_pkg::SHIFT_CNT_W] = st.shifts;
    end

    always_comb begin
        next_st = st;
        next_st.mode_sy = {st.mode_sy[0], chain_split_i};
        next_st.dir_sy = {st.dir_sy[0], shift_direction_select_i};
        next_st.phase_sy = {st.phase_sy[0], ac_phase_i};
        next_st.blank_n_sy = {st.blank_n_sy[0], display_blank_n_i};
        next_st.tgl_sy = {st.tgl_sy[1:0], lnk.shift_tgl};
        if (shift_seen) begin
            next_st.scan = lnk.stage;
            next_st.shifts = st.shifts + 1'b1;
        end
        next_st.low_oe = !st.mode_sy[1] && st.dir_sy[1];
        next_st.high_oe = !st.mode_sy[1] && !st.dir_sy[1];
        for (int i = 0; i < NUM_ROWS; i++) begin
            next_st.rows[i] = row_level(st.scan[i], st.phase_sy[1],
                st.blank_n_sy[1] && st.drive_en);
        end
        // single-cycle classic answer; unmapped reads return zero
        next_st.ack = req;
        if (req) begin
            unique case (wb_adr_i)
                lcss_pkg::ADR_CTRL: begin
                    next_st.rdata = 32'(st.drive_en);
                end
                lcss_pkg::ADR_STATUS: begin
                    next_st.rdata = status_w;
                end
                lcss_pkg::ADR_SCAN0: begin
                    next_st.rdata = scan_ext[31:0];
                end
                lcss_pkg::ADR_SCAN1: begin
                    next_st.rdata = scan_ext[63:32];
                end
                lcss_pkg::ADR_SCAN2: begin
                    next_st.rdata = scan_ext[95:64];
                end
                default: begin
                    next_st.rdata = 32'h0000_0000;
                end
            endcase
            if (wb_we_i && wb_adr_i == lcss_pkg::ADR_CTRL && wb_sel_i[0]) begin
                next_st.drive_en = wb_dat_i[lcss_pkg::CTRL_DRIVE_EN_BIT];
            end
        end
        if (rst_i) begin
            next_st = '0;
            next_st.drive_en = lcss_pkg::CTRL_DRIVE_EN_RESET;
            for (int i = 0; i < NUM_ROWS; i++) begin
                next_st.rows[i] = lcss_pkg::LVL_UPPER_NONSEL;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        st <= next_st;
    end

    assign wb_ack_o = st.ack;
    assign wb_dat_o = st.rdata;
    assign low_end_data_io_oe_o = st.low_oe;
    assign high_end_data_io_oe_o = st.high_oe;
    assign row_level_o = st.rows;

    // select levels are the codes whose two bits agree
    for (genvar g = 0; g < NUM_ROWS; g++) begin : g_sel
        assign row_is_sel[g] = row_level_o[g][1] == row_level_o[g][0];
    end

    property p_ack_pulse;
        @(posedge clk_i) disable iff (rst_i)
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("bus answer not a one-cycle ack");

    property p_ctrl_write;
        @(posedge clk_i) disable iff (rst_i)
        req && wb_we_i && wb_adr_i == lcss_pkg::ADR_CTRL && wb_sel_i[0]
        |=> st.drive_en == $past(wb_dat_i[0]);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost");

    property p_blank_rows;
        @(posedge clk_i) disable iff (rst_i)
        !st.blank_n_sy[1] |=> row_is_sel == '0;
    endproperty
    a_blank_rows: assert property (p_blank_rows) else $error("row selected while blanked");

    property p_soft_blank;
        @(posedge clk_i) disable iff (rst_i)
        !st.drive_en ##1 !st.drive_en |=> row_is_sel == '0;
    endproperty
    a_soft_blank: assert property (p_soft_blank) else $error("row selected while drive off");

    property p_row_bottom;
        @(posedge clk_i) disable iff (rst_i)
        st.phase_sy[1] && st.blank_n_sy[1] && st.drive_en && st.scan[0]
        |=> row_level_o[0] == lcss_pkg::LVL_BOTTOM_SEL;
    endproperty
    a_row_bottom: assert property (p_row_bottom) else $error("first row not bottom select");

    property p_row_top;
        @(posedge clk_i) disable iff (rst_i)
        !st.phase_sy[1] && st.blank_n_sy[1] && st.drive_en && st.scan[0]
        |=> row_level_o[0] == lcss_pkg::LVL_TOP_SEL;
    endproperty
    a_row_top: assert property (p_row_top) else $error("first row not top select");

    property p_row_nonsel;
        @(posedge clk_i) disable iff (rst_i)
        st.phase_sy[1] && !st.scan[NUM_ROWS-1]
        |=> row_level_o[NUM_ROWS-1] == lcss_pkg::LVL_LOWER_NONSEL;
    endproperty
    a_row_nonsel: assert property (p_row_nonsel) else $error("last row not lower non-select");

    property p_oe_single_up;
        @(posedge clk_i) disable iff (rst_i)
        !st.mode_sy[1] && !st.dir_sy[1] |=> high_end_data_io_oe_o && !low_end_data_io_oe_o;
    endproperty
    a_oe_single_up: assert property (p_oe_single_up) else $error("upward pin roles wrong");

    property p_oe_split;
        @(posedge clk_i) disable iff (rst_i)
        st.mode_sy[1] |=> !high_end_data_io_oe_o && !low_end_data_io_oe_o;
    endproperty
    a_oe_split: assert property (p_oe_split) else $error("end pin driven in split mode");

    property p_shift_count;
        @(posedge clk_i) disable iff (rst_i)
        shift_seen |=> st.shifts == $past(st.shifts) + 1'b1 && st.scan == $past(lnk.stage);
    endproperty
    a_shift_count: assert property (p_shift_count) else $error("shift not captured");

    // scan copy and count move only on a seen link edge
    property p_scan_hold;
        @(posedge clk_i) disable iff (rst_i)
        !shift_seen |=> $stable(st.scan) && $stable(st.shifts);
    endproperty
    a_scan_hold: assert property (p_scan_hold) else $error("scan copy moved without shift");

    property p_oe_down;
        @(posedge clk_i) disable iff (rst_i)
        !st.mode_sy[1] && st.dir_sy[1] |=> low_end_data_io_oe_o && !high_end_data_io_oe_o;
    endproperty
    a_oe_down: assert property (p_oe_down) else $error("down pin roles wrong");

    property p_row_upper;
        @(posedge clk_i) disable iff (rst_i)
        !st.phase_sy[1] && !st.scan[0] |=> row_level_o[0] == lcss_pkg::LVL_UPPER_NONSEL;
    endproperty
    a_row_upper: assert property (p_row_upper) else $error("first row not upper non-select");

    property p_last_top;
        @(posedge clk_i) disable iff (rst_i)
        !st.phase_sy[1] && st.blank_n_sy[1] && st.drive_en && st.scan[NUM_ROWS-1]
        |=> row_level_o[NUM_ROWS-1] == lcss_pkg::LVL_TOP_SEL;
    endproperty
    a_last_top: assert property (p_last_top) else $error("last row not top select");

    property p_blank_level;
        @(posedge clk_i) disable iff (rst_i)
        !st.blank_n_sy[1] && st.phase_sy[1] |=> row_level_o[0] == lcss_pkg::LVL_LOWER_NONSEL;
    endproperty
    a_blank_level: assert property (p_blank_level) else $error("blank level wrong");

    property p_scan0_read;
        @(posedge clk_i) disable iff (rst_i)
        req && !wb_we_i && wb_adr_i == lcss_pkg::ADR_SCAN0
        |=> wb_dat_o == $past(scan_ext[31:0]);
    endproperty
    a_scan0_read: assert property (p_scan0_read) else $error("scan word read wrong");

    property p_count_read;
        @(posedge clk_i) disable iff (rst_i)
        req && !wb_we_i && wb_adr_i == lcss_pkg::ADR_STATUS
        |=> wb_dat_o[31:16] == $past(st.shifts);
    endproperty
    a_count_read: assert property (p_count_read) else $error("shift count read wrong");

    property p_status_read;
        @(posedge clk_i) disable iff (rst_i)
        req && !wb_we_i && wb_adr_i == lcss_pkg::ADR_STATUS
        |=> wb_dat_o[3:0] == $past({st.blank_n_sy[1], st.phase_sy[1], st.dir_sy[1],
            st.mode_sy[1]});
    endproperty
    a_status_read: assert property (p_status_read) else $error("status bits read wrong");

    // read data must stand until software takes the next word
    property p_dat_hold;
        @(posedge clk_i) disable iff (rst_i)
        !req |=> $stable(wb_dat_o);
    endproperty
    a_dat_hold: assert property (p_dat_hold) else $error("read data moved without request");

    property p_ack_idle;
        @(posedge clk_i) disable iff (rst_i)
        !wb_cyc_i |=> !wb_ack_o;
    endproperty
    a_ack_idle: assert property (p_ack_idle) else $error("ack without cycle");

    property p_reset_out;
        @(posedge clk_i)
        rst_i |=> !wb_ack_o && !low_end_data_io_oe_o && !high_end_data_io_oe_o;
    endproperty
    a_reset_out: assert property (p_reset_out) else $error("outputs active in reset");

    c_blank: cover property (@(posedge clk_i) disable iff (rst_i)
        !st.blank_n_sy[1] ##1 st.blank_n_sy[1]);
    c_scan_read: cover property (@(posedge clk_i) disable iff (rst_i)
        req && !wb_we_i && wb_adr_i == lcss_pkg::ADR_SCAN2);
    c_phase_flip: cover property (@(posedge clk_i) disable iff (rst_i)
        shift_seen && st.phase_sy[1] ##1 !st.phase_sy[1]);
    c_single_down: cover property (@(posedge clk_i) disable iff (rst_i)
        shift_seen && !st.mode_sy[1] && st.dir_sy[1]);
endmodule : lcss_top

// *** core/lcss_pkg.sv ***
// shared constants for the lcd common scan shifter
package lcss_pkg;
    localparam int NUM_ROWS = 80;
    localparam int HALF_ROWS = 40;
    localparam int SCAN_W = 96;
    localparam int SHIFT_CNT_W = 16;
    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_STATUS = 8'h04;
    localparam logic [7:0] ADR_SCAN0 = 8'h08;
    localparam logic [7:0] ADR_SCAN1 = 8'h0C;
    localparam logic [7:0] ADR_SCAN2 = 8'h10;
    localparam logic CTRL_DRIVE_EN_RESET = 1'h1;
    localparam int CTRL_DRIVE_EN_BIT = 0;
    localparam int ST_MODE_BIT = 0;
    localparam int ST_DIR_BIT = 1;
    localparam int ST_PHASE_BIT = 2;
    localparam int ST_BLANK_N_BIT = 3;
    localparam int ST_COUNT_LSB = 16;
    typedef enum logic [1:0] {
        LVL_TOP_SEL,
        LVL_UPPER_NONSEL,
        LVL_LOWER_NONSEL,
        LVL_BOTTOM_SEL
    } lcss_level_t;
endpackage : lcss_pkg

// *** core/lcss_link_if.sv ***
// signals between the link-side shifter and the bus-side core
`timescale 1ns/1ns
interface lcss_link_if #(
    parameter int NUM_ROWS = lcss_pkg::NUM_ROWS
);
    logic low_in;
    logic high_in;
    logic second_in;
    logic dual_mode;
    logic shift_down;
    logic [NUM_ROWS-1:0] stage;
    logic shift_tgl;
    modport shifter (
        input low_in, high_in, second_in, dual_mode, shift_down,
        output stage, shift_tgl
    );
    modport core (
        output low_in, high_in, second_in, dual_mode, shift_down,
        input stage, shift_tgl
    );
endinterface : lcss_link_if

// *** core/lcss_shifter.sv ***
// scan shift register on the falling edge of the link clock
`timescale 1ns/1ns
module lcss_shifter #(
    parameter int NUM_ROWS = lcss_pkg::NUM_ROWS,
    parameter int HALF_ROWS = lcss_pkg::HALF_ROWS
) (
    input wire logic scan_shift_clock_i,
    lcss_link_if.shifter lnk
);
    typedef struct packed {
        logic [NUM_ROWS-1:0] stage;
        logic shift_tgl;
    } lcss_shf_t;

    // no reset exists on this clock; power-up value keeps the toggle defined
    lcss_shf_t st = '0;
    lcss_shf_t next_st;
    logic [NUM_ROWS-1:0] up_v;
    logic [NUM_ROWS-1:0] dn_v;
    logic primed = 1'b0;

    if (NUM_ROWS != 2 * HALF_ROWS || HALF_ROWS < 2) begin : g_bad_size
        $error("lcss_shifter: rows must be two equal halves");
    end

    always_comb begin
        up_v = {st.stage[NUM_ROWS-2:0], lnk.low_in};
        dn_v = {lnk.high_in, st.stage[NUM_ROWS-1:1]};
        if (lnk.dual_mode) begin
            up_v[HALF_ROWS] = lnk.second_in;
        end
        if (lnk.dual_mode) begin
            dn_v[HALF_ROWS-1] = lnk.second_in;
        end
        next_st = st;
        next_st.stage = lnk.shift_down ? dn_v : up_v;
        next_st.shift_tgl = !st.shift_tgl;
    end

    always_ff @(negedge scan_shift_clock_i) begin
        st <= next_st;
    end

    always_ff @(negedge scan_shift_clock_i) begin
        primed <= 1'b1;
    end

    assign lnk.stage = st.stage;
    assign lnk.shift_tgl = st.shift_tgl;

    property p_single_up;
        @(negedge scan_shift_clock_i) disable iff (!primed)
        !$past(lnk.dual_mode) && !$past(lnk.shift_down)
        |-> st.stage[0] == $past(lnk.low_in)
            && st.stage[NUM_ROWS-1:1] == $past(st.stage[NUM_ROWS-2:0]);
    endproperty
    a_single_up: assert property (p_single_up) else $error("single upward shift wrong");

    property p_single_down;
        @(negedge scan_shift_clock_i) disable iff (!primed)
        !$past(lnk.dual_mode) && $past(lnk.shift_down)
        |-> st.stage[NUM_ROWS-1] == $past(lnk.high_in)
            && st.stage[NUM_ROWS-2:0] == $past(st.stage[NUM_ROWS-1:1]);
    endproperty
    a_single_down: assert property (p_single_down) else $error("single downward shift wrong");

    property p_dual_up;
        @(negedge scan_shift_clock_i) disable iff (!primed)
        $past(lnk.dual_mode) && !$past(lnk.shift_down)
        |-> st.stage[HALF_ROWS] == $past(lnk.second_in)
            && st.stage[0] == $past(lnk.low_in)
            && st.stage[HALF_ROWS-1] == $past(st.stage[HALF_ROWS-2]);
    endproperty
    a_dual_up: assert property (p_dual_up) else $error("dual upward shift wrong");

    property p_dual_down;
        @(negedge scan_shift_clock_i) disable iff (!primed)
        $past(lnk.dual_mode) && $past(lnk.shift_down)
        |-> st.stage[HALF_ROWS-1] == $past(lnk.second_in)
            && st.stage[NUM_ROWS-1] == $past(lnk.high_in)
            && st.stage[HALF_ROWS] == $past(st.stage[HALF_ROWS+1]);
    endproperty
    a_dual_down: assert property (p_dual_down) else $error("dual downward shift wrong");

    c_dual_down: cover property (@(negedge scan_shift_clock_i)
        primed && lnk.dual_mode && lnk.shift_down);
endmodule : lcss_shifter

// *** tb/lcss_ctrl_model.sv ***
// display controller model: scan clock, serial data and ac phase
`timescale 1ns/1ns
module lcss_ctrl_model (
    input wire logic run_i,
    input wire logic split_i,
    input wire logic low_bit_i,
    input wire logic high_bit_i,
    input wire logic second_bit_i,
    output logic scan_shift_clock_o,
    output logic low_o,
    output logic high_o,
    output logic second_o,
    output logic ac_phase_o
);
    int edges = 0;
    // clock stands high between frames
    initial begin
        scan_shift_clock_o = 1'b1;
        {low_o, high_o, second_o, ac_phase_o} = 4'h0;
        #1;
        forever begin
            if (run_i) begin
                #62 scan_shift_clock_o = 1'b0;
                #63 scan_shift_clock_o = 1'b1;
            end else begin
                #5;
            end
        end
    end
    // data moves on the rising edge, far from the falling sample
    always @(posedge scan_shift_clock_o) begin
        low_o <= low_bit_i;
        high_o <= high_bit_i;
        second_o <= split_i ? second_bit_i : 1'b1;
    end
    always @(negedge scan_shift_clock_o) begin
        edges <= edges + 1;
        if (edges % 3 == 2) begin
            ac_phase_o <= ~ac_phase_o;
        end
    end
endmodule : lcss_ctrl_model

// *** tb/lcss_top_test.sv ***
// self-checking bench for the lcd common scan shifter
`timescale 1ns/1ns
module lcss_top_test;
    logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [7:0] wb_adr_i, lfsr;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic sclk, lo_o, lo_oe, hi_o, hi_oe, lo_m, hi_m, sec, split, dir, phase, blank_n;
    logic run, lo_bit, hi_bit, sec_bit, lo_w, hi_w;
    logic [lcss_pkg::NUM_ROWS-1:0][1:0] rows;
    logic [79:0] scan = '0;
    int errors = 0;
    int total_checks = 0;
    int nfall = 0;
    // the pin level: whoever enables wins, the model only fills in
    assign lo_w = lo_oe ? lo_o : lo_m;
    assign hi_w = hi_oe ? hi_o : hi_m;
    lcss_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .scan_shift_clock_i(sclk),
        .low_end_data_io_i(lo_w), .low_end_data_io_o(lo_o), .low_end_data_io_oe_o(lo_oe),
        .high_end_data_io_i(hi_w), .high_end_data_io_o(hi_o), .high_end_data_io_oe_o(hi_oe),
        .second_chain_input_i(sec), .chain_split_i(split), .shift_direction_select_i(dir),
        .ac_phase_i(phase), .display_blank_n_i(blank_n), .row_level_o(rows));
    lcss_ctrl_model ctrl (.run_i(run), .split_i(split), .low_bit_i(lo_bit),
        .high_bit_i(hi_bit), .second_bit_i(sec_bit), .scan_shift_clock_o(sclk),
        .low_o(lo_m), .high_o(hi_m), .second_o(sec), .ac_phase_o(phase));
    function automatic logic [7:0] lfsr_next(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction : lfsr_next
    function automatic logic [79:0] shift_ref(input logic [79:0] s, input logic sp, dn, l, h, c);
        case ({sp, dn})
            2'b00: return {s[78:0], l};
            2'b01: return {h, s[79:1]};
            2'b10: return {s[78:40], c, s[38:0], l};
            default: return {h, s[79:41], c, s[39:1]};
        endcase
    endfunction : shift_ref
    function automatic logic [159:0] rows_ref(input logic [79:0] s, input logic ph, show);
        logic [159:0] r;
        logic [1:0] sl;
        logic [1:0] ns;
        sl = ph ? lcss_pkg::LVL_BOTTOM_SEL : lcss_pkg::LVL_TOP_SEL;
        ns = ph ? lcss_pkg::LVL_LOWER_NONSEL : lcss_pkg::LVL_UPPER_NONSEL;
        for (int i = 0; i < 80; i++) begin
            r[2*i +: 2] = (show && s[i]) ? sl : ns;
        end
        return r;
    endfunction : rows_ref
    task automatic check(input string what, input logic [159:0] got, input logic [159:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic conclude;
        if (errors == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : conclude
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        int n;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        n = 0;
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1 && n < 20) begin
            @(posedge clk_i);
            n++;
        end
        if (wb_ack_o !== 1'b1) begin
            errors++;
            conclude();
        end
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask : wb
    task automatic wait_fall;
        int n0;
        int t;
        n0 = nfall;
        t = 0;
        while (nfall == n0 && t < 100) begin
            @(posedge clk_i);
            t++;
        end
        if (nfall == n0) begin
            errors++;
            conclude();
        end
    endtask : wait_fall
    // reference chain follows the pin levels at each falling edge
    always @(negedge sclk) begin
        nfall++;
        scan = shift_ref(scan, split, dir, lo_w, hi_w, sec);
    end
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    initial begin
        {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, run} = 5'h10;
        {split, dir, lo_bit, hi_bit, sec_bit, blank_n} = 6'h01;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'hF;
        wb_dat_i = 32'h0;
        lfsr = 8'h2C;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        check("rows_reset", rows, rows_ref('0, phase, 1'b1));
        wb(1'b0, lcss_pkg::ADR_CTRL, 32'h0);
        check("ctrl_reset", rd[0], lcss_pkg::CTRL_DRIVE_EN_RESET);
        run <= 1'b1;
        for (int m = 0; m < 4; m++) begin
            split <= m[1];
            dir <= m[0];
            for (int k = 0; k < 30; k++) begin
                wait_fall();
                lfsr = lfsr_next(lfsr);
                {lo_bit, hi_bit, sec_bit} <= lfsr[2:0];
                // blank one edge per mode only, the eighth; the next edge releases it
                blank_n <= (k == 7) ? 1'b0 : 1'b1;
                repeat (20) @(posedge clk_i);
                check("rows", rows, rows_ref(scan, phase, blank_n));
                check("oe", {lo_oe, hi_oe}, split ? 2'b00 : (dir ? 2'b10 : 2'b01));
                if (!split) begin
                    check("end_out", dir ? lo_o : hi_o, dir ? scan[0] : scan[79]);
                end
            end
        end
        run <= 1'b0;
        repeat (200) @(posedge clk_i);
        wb(1'b0, lcss_pkg::ADR_SCAN0, 32'h0);
        check("scan0", rd, scan[31:0]);
        wb(1'b0, lcss_pkg::ADR_SCAN1, 32'h0);
        check("scan1", rd, scan[63:32]);
        wb(1'b0, lcss_pkg::ADR_SCAN2, 32'h0);
        check("scan2", rd, {16'h0, scan[79:64]});
        wb(1'b1, lcss_pkg::ADR_STATUS, 32'hFFFFFFFF);
        wb(1'b0, lcss_pkg::ADR_STATUS, 32'h0);
        check("count", rd[31:16], nfall[15:0]);
        check("status", rd[3:0], {blank_n, phase, dir, split});
        wb(1'b1, 8'h20, 32'hFFFFFFFF);
        wb(1'b0, 8'h20, 32'h0);
        check("unmapped", rd, 32'h0);
        // software blank through the control word
        wb(1'b1, lcss_pkg::ADR_CTRL, 32'h0);
        repeat (4) @(posedge clk_i);
        check("rows_off", rows, rows_ref(scan, phase, 1'b0));
        wb(1'b1, lcss_pkg::ADR_CTRL, 32'h1);
        repeat (4) @(posedge clk_i);
        check("rows_on", rows, rows_ref(scan, phase, 1'b1));
        conclude();
    end
endmodule : lcss_top_test
